// *** hw/pcr_cmd.sv ***
`timescale 1ns/10ps

// Notes on behaviour
// - Probe-arm command code 6Ch; first argument byte echoed to memory on interrupt.
// - Second argument picks the probe: 1 is input zero, 2 is input one.
// - Once armed, only the first falling edge on the chosen input counts.
// - On that edge stop all axes and latch every axis position.
// - Position handover uses a card handshake byte and a host handshake byte.
// - Probe interrupt is raised only once the axes have stopped.
// - Probe interrupt writes occurrence and source echo into two status bytes.
// - Probe interrupt sets flag bit 1 in the host flag bytes.
// - One probe armed at a time; a new arm replaces the old one.
// - Probe arming and index-pulse arming coexist without cancelling each other.
// - Reset command code 72h carries signature AAh in both argument bytes.
// - A valid reset returns probe, stop, position, status and handshake state to its power-up values.
// - Reset completion sets flag bit 4 in the host flag bytes.
// - Feedback fault records occurrence and source axes in two status bytes.
// - Feedback fault sets flag bit 6 in the host flag bytes.
// - Axis bytes are bit coded, bit zero axis one up to bit three.
module pcr_cmd (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         cmd_valid,
  input  wire logic [7:0]   cmd_code,
  input  wire logic [7:0]   cmd_arg_a,
  input  wire logic [7:0]   cmd_arg_b,
  input  wire logic         probe_input_zero,
  input  wire logic         probe_input_one,
  input  wire logic         axes_stopped,
  input  wire logic [127:0] actual_pos,
  input  wire logic         fb_fault_valid,
  input  wire logic [3:0]   fb_fault_axes,
  input  wire logic [10:0]  hp_addr,
  input  wire logic         hp_wr,
  input  wire logic         hp_rd,
  input  wire logic [7:0]   hp_wdata,
  output logic      [7:0]   hp_rdata,
  output logic              stop_all_axes,
  output logic              soft_reset_pulse,
  output logic              host_irq
);

  pcr_pkg::pcr_probe_state_type state_q;

  logic [1:0]  probe_fall;
  logic        cmd_arm;
  logic        cmd_rst;
  logic        arm_take;
  logic        edge_sel;
  logic        irq_evt;
  logic        soft_rst_q;
  logic        stop_q;
  logic [7:0]  arm_n_q;
  logic [7:0]  arm_m_q;
  logic [31:0] pos_q [pcr_pkg::AXES];
  logic [7:0]  probe_evt_q;
  logic [7:0]  probe_src_q;
  logic [7:0]  fb_stat_q;
  logic [7:0]  fb_src_q;
  logic [7:0]  hs_card_q;
  logic [7:0]  hs_host_q;
  logic [7:0]  flag_lo_q;
  logic [7:0]  flag_a_q;
  logic [7:0]  flag_b_q;
  logic [7:0]  rdata_q;
  logic [7:0]  set_lo;
  logic [7:0]  set_a;
  logic [7:0]  set_b;

  pcr_probe_sync u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pin_in  ({probe_input_one, probe_input_zero}),
    .level   (),
    .fall    (probe_fall)
  );

  // Host byte read of the captured position block, little endian per axis
  function automatic logic [7:0] pos_byte(input logic [10:0] addr);
    logic [10:0] idx;
    logic [31:0] word;
    idx  = addr - pcr_pkg::OFS_POS_FIRST;
    word = pos_q[idx[3:2]];
    case (idx[1:0])
      2'h0:    pos_byte = word[7:0];
      2'h1:    pos_byte = word[15:8];
      2'h2:    pos_byte = word[23:16];
      default: pos_byte = word[31:24];
    endcase
  endfunction

  // Command decode
  assign cmd_arm = cmd_valid && (cmd_code == pcr_pkg::CMD_PROBE_ARM)
                   && ((cmd_arg_b == pcr_pkg::SEL_PROBE_ZERO) || (cmd_arg_b == pcr_pkg::SEL_PROBE_ONE));
  assign cmd_rst = cmd_valid && (cmd_code == pcr_pkg::CMD_SOFT_RESET)
                   && (cmd_arg_a == pcr_pkg::RESET_SIG) && (cmd_arg_b == pcr_pkg::RESET_SIG);
  assign arm_take = cmd_arm && (state_q != pcr_pkg::PRB_STOPPING);
  assign edge_sel = (arm_m_q == pcr_pkg::SEL_PROBE_ZERO) ? probe_fall[0] : probe_fall[1];
  assign irq_evt  = (state_q == pcr_pkg::PRB_STOPPING) && axes_stopped && !soft_rst_q;

  // Soft reset strobe, one cycle after a valid command
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= cmd_rst;
    end
  end

  // Probe sequencer; index-pulse arming lives elsewhere and is never touched here
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= pcr_pkg::PRB_IDLE;
    end else if (soft_rst_q) begin
      state_q <= pcr_pkg::PRB_IDLE;
    end else begin
      case (state_q)
        pcr_pkg::PRB_IDLE: begin
          if (arm_take) begin
            state_q <= pcr_pkg::PRB_ARMED;
          end
        end
        pcr_pkg::PRB_ARMED: begin
          if (arm_take) begin
            state_q <= pcr_pkg::PRB_ARMED;
          end else if (edge_sel) begin
            state_q <= pcr_pkg::PRB_STOPPING;
          end
        end
        pcr_pkg::PRB_STOPPING: begin
          if (axes_stopped) begin
            state_q <= pcr_pkg::PRB_IDLE;
          end
        end
        default: begin
          state_q <= pcr_pkg::PRB_IDLE;
        end
      endcase
    end
  end

  // Armed arguments; a new arm outside PRB_STOPPING overwrites the previous source
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_n_q <= pcr_pkg::BYTE_RESET;
      arm_m_q <= pcr_pkg::BYTE_RESET;
    end else if (soft_rst_q) begin
      arm_n_q <= pcr_pkg::BYTE_RESET;
      arm_m_q <= pcr_pkg::BYTE_RESET;
    end else if (arm_take) begin
      arm_n_q <= cmd_arg_a;
      arm_m_q <= cmd_arg_b;
    end
  end

  // Stop request held until every axis reports standstill
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_q <= 1'b0;
    end else if (soft_rst_q) begin
      stop_q <= 1'b0;
    end else if ((state_q == pcr_pkg::PRB_ARMED) && !arm_take && edge_sel) begin
      stop_q <= 1'b1;
    end else if (axes_stopped) begin
      stop_q <= 1'b0;
    end
  end

  // Position latch for every axis at the probe edge
  generate
    for (genvar g = 0; g < pcr_pkg::AXES; g++) begin : g_pos
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pos_q[g] <= pcr_pkg::POS_RESET;
        end else if (soft_rst_q) begin
          pos_q[g] <= pcr_pkg::POS_RESET;
        end else if ((state_q == pcr_pkg::PRB_ARMED) && !arm_take && edge_sel) begin
          pos_q[g] <= actual_pos[g*pcr_pkg::POS_BITS +: pcr_pkg::POS_BITS];
        end
      end
    end
  endgenerate

  // Probe status bytes
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      probe_evt_q <= pcr_pkg::BYTE_RESET;
      probe_src_q <= pcr_pkg::BYTE_RESET;
    end else if (soft_rst_q) begin
      probe_evt_q <= pcr_pkg::BYTE_RESET;
      probe_src_q <= pcr_pkg::BYTE_RESET;
    end else if (irq_evt) begin
      probe_evt_q <= arm_n_q;
      probe_src_q <= arm_m_q;
    end
  end

  // Feedback fault status bytes, source axes bit coded
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fb_stat_q <= pcr_pkg::BYTE_RESET;
      fb_src_q  <= pcr_pkg::BYTE_RESET;
    end else if (soft_rst_q) begin
      fb_stat_q <= pcr_pkg::BYTE_RESET;
      fb_src_q  <= pcr_pkg::BYTE_RESET;
    end else if (fb_fault_valid) begin
      fb_stat_q <= pcr_pkg::FB_OCCURRED;
      fb_src_q  <= {4'h0, fb_fault_axes};
    end
  end

  // Capture handshake; a new capture wins over a host acknowledge
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_card_q <= pcr_pkg::BYTE_RESET;
      hs_host_q <= pcr_pkg::BYTE_RESET;
    end else if (soft_rst_q) begin
      hs_card_q <= pcr_pkg::BYTE_RESET;
      hs_host_q <= pcr_pkg::BYTE_RESET;
    end else begin
      if (hp_wr && (hp_addr == pcr_pkg::OFS_HS_HOST)) begin
        hs_host_q <= hp_wdata;
      end
      if (irq_evt) begin
        hs_card_q <= pcr_pkg::HS_READY;
      end else if (hp_wr && (hp_addr == pcr_pkg::OFS_HS_HOST) && (hp_wdata != pcr_pkg::BYTE_RESET)) begin
        hs_card_q <= pcr_pkg::BYTE_RESET;
      end
    end
  end

  // Host flag sets
  always_comb begin
    set_lo = 8'h00;
    set_a  = 8'h00;
    set_b  = 8'h00;
    if (irq_evt) begin
      set_lo[pcr_pkg::FLAG_PROBE_BIT] = 1'b1;
      set_a[pcr_pkg::FLAG_PROBE_BIT]  = 1'b1;
    end
    if (fb_fault_valid) begin
      set_lo[pcr_pkg::FLAG_FAULT_BIT] = 1'b1;
      set_a[pcr_pkg::FLAG_FAULT_BIT]  = 1'b1;
    end
  end

  // Flag bytes clear on host read; sets in the same cycle survive
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_lo_q <= pcr_pkg::BYTE_RESET;
      flag_a_q  <= pcr_pkg::BYTE_RESET;
      flag_b_q  <= pcr_pkg::BYTE_RESET;
    end else if (soft_rst_q) begin
      flag_lo_q <= pcr_pkg::FLAG_RESET_MASK;
      flag_a_q  <= pcr_pkg::BYTE_RESET;
      flag_b_q  <= pcr_pkg::FLAG_RESET_MASK;
    end else begin
      flag_lo_q <= ((hp_rd && (hp_addr == pcr_pkg::OFS_IRQ_LOW)) ? 8'h00 : flag_lo_q) | set_lo;
      flag_a_q  <= ((hp_rd && (hp_addr == pcr_pkg::OFS_IRQ_HIGH_A)) ? 8'h00 : flag_a_q) | set_a;
      flag_b_q  <= ((hp_rd && (hp_addr == pcr_pkg::OFS_IRQ_HIGH_B)) ? 8'h00 : flag_b_q) | set_b;
    end
  end

  // Host read port, unmapped bytes read zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= pcr_pkg::BYTE_RESET;
    end else if (hp_rd) begin
      if ((hp_addr >= pcr_pkg::OFS_POS_FIRST) && (hp_addr <= pcr_pkg::OFS_POS_LAST)) begin
        rdata_q <= pos_byte(hp_addr);
      end else begin
        case (hp_addr)
          pcr_pkg::OFS_PROBE_EVENT: rdata_q <= probe_evt_q;
          pcr_pkg::OFS_PROBE_ECHO:  rdata_q <= probe_src_q;
          pcr_pkg::OFS_FB_STATUS:   rdata_q <= fb_stat_q;
          pcr_pkg::OFS_FB_SOURCE:   rdata_q <= fb_src_q;
          pcr_pkg::OFS_HS_CARD:     rdata_q <= hs_card_q;
          pcr_pkg::OFS_HS_HOST:     rdata_q <= hs_host_q;
          pcr_pkg::OFS_IRQ_LOW:     rdata_q <= flag_lo_q;
          pcr_pkg::OFS_IRQ_HIGH_A:  rdata_q <= flag_a_q;
          pcr_pkg::OFS_IRQ_HIGH_B:  rdata_q <= flag_b_q;
          default:                  rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign hp_rdata         = rdata_q;
  assign stop_all_axes    = stop_q;
  assign soft_reset_pulse = soft_rst_q;
  assign host_irq         = |{flag_lo_q, flag_a_q, flag_b_q};

  // Checks
  sequence s_valid_reset;
    cmd_rst ##1 soft_rst_q;
  endsequence

  sequence s_probe_hit;
    (state_q == pcr_pkg::PRB_ARMED) && !arm_take && edge_sel && !soft_rst_q;
  endsequence

  a_arm_replaces: assert property (@(posedge ref_clk) disable iff (!arst_n)
    arm_take && !soft_rst_q |=> (state_q == pcr_pkg::PRB_ARMED) && (arm_m_q == $past(cmd_arg_b)))
    else $error("probe arm not taken");

  a_sel_one_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (state_q == pcr_pkg::PRB_ARMED) && (arm_m_q == pcr_pkg::SEL_PROBE_ONE) && !probe_fall[1]
    && !arm_take && !soft_rst_q |=> state_q == pcr_pkg::PRB_ARMED)
    else $error("unselected probe edge acted on");

  a_edge_captures: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_probe_hit |=> stop_q && (state_q == pcr_pkg::PRB_STOPPING) && (pos_q[3] == $past(actual_pos[127:96])))
    else $error("probe edge did not stop and capture");

  a_irq_after_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(flag_a_q[pcr_pkg::FLAG_PROBE_BIT]) |-> $past(axes_stopped) && ($past(state_q) == pcr_pkg::PRB_STOPPING))
    else $error("probe flag raised before standstill");

  a_probe_echo: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq_evt |=> (probe_evt_q == $past(arm_n_q)) && (probe_src_q == $past(arm_m_q)))
    else $error("probe source echo wrong");

  a_probe_flags: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq_evt |=> flag_lo_q[pcr_pkg::FLAG_PROBE_BIT] && flag_a_q[pcr_pkg::FLAG_PROBE_BIT])
    else $error("probe flag bit not set");

  a_handshake_set: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq_evt |=> hs_card_q == pcr_pkg::HS_READY)
    else $error("card handshake not set");

  a_probe_disarm: assert property (@(posedge ref_clk) disable iff (!arst_n)
    irq_evt |=> (state_q == pcr_pkg::PRB_IDLE) ##1 (state_q != pcr_pkg::PRB_STOPPING))
    else $error("probe not disarmed");

  a_reset_done: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_valid_reset |=> (state_q == pcr_pkg::PRB_IDLE) && (flag_b_q == pcr_pkg::FLAG_RESET_MASK) && !stop_q)
    else $error("reset did not complete");

  a_reset_ignore: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cmd_valid && (cmd_code == pcr_pkg::CMD_SOFT_RESET)
    && ((cmd_arg_a != pcr_pkg::RESET_SIG) || (cmd_arg_b != pcr_pkg::RESET_SIG)) |=> !soft_rst_q)
    else $error("bad signature accepted");

  a_fault_record: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fb_fault_valid && !soft_rst_q |=> (fb_src_q[3:0] == $past(fb_fault_axes)) && (fb_stat_q == pcr_pkg::FB_OCCURRED))
    else $error("fault source not recorded");

  a_fault_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fb_fault_valid && !soft_rst_q |=> flag_lo_q[pcr_pkg::FLAG_FAULT_BIT] && flag_a_q[pcr_pkg::FLAG_FAULT_BIT])
    else $error("fault flag bit not set");

endmodule

// *** inc/pcr_pkg.sv ***
package pcr_pkg;

  // Command codes and arguments
  localparam logic [7:0] CMD_PROBE_ARM  = 8'h6C;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h72;
  localparam logic [7:0] RESET_SIG      = 8'hAA;
  localparam logic [7:0] SEL_PROBE_ZERO = 8'h01;
  localparam logic [7:0] SEL_PROBE_ONE  = 8'h02;

  // Shared memory offsets
  localparam logic [10:0] OFS_PROBE_EVENT   = 11'h000;
  localparam logic [10:0] OFS_PROBE_ECHO    = 11'h006;
  localparam logic [10:0] OFS_FB_STATUS     = 11'h009;
  localparam logic [10:0] OFS_FB_SOURCE     = 11'h00A;
  localparam logic [10:0] OFS_POS_FIRST     = 11'h0A7;
  localparam logic [10:0] OFS_POS_LAST      = 11'h0B6;
  localparam logic [10:0] OFS_HS_CARD       = 11'h0C8;
  localparam logic [10:0] OFS_HS_HOST       = 11'h0D0;
  localparam logic [10:0] OFS_IRQ_LOW       = 11'h3FE;
  localparam logic [10:0] OFS_IRQ_HIGH_A    = 11'h7EF;
  localparam logic [10:0] OFS_IRQ_HIGH_B    = 11'h7FE;

  // Field positions and values
  localparam int         FLAG_PROBE_BIT   = 1;
  localparam int         FLAG_RESET_BIT   = 4;
  localparam int         FLAG_FAULT_BIT   = 6;
  localparam logic [7:0] FLAG_RESET_MASK  = 8'h10;
  localparam logic [7:0] FB_OCCURRED      = 8'h01;
  localparam logic [7:0] HS_READY         = 8'h01;
  localparam logic [7:0] BYTE_RESET       = 8'h00;
  localparam logic [31:0] POS_RESET       = 32'h0000_0000;
  localparam int         AXES             = 4;
  localparam int         POS_BITS         = 32;

  typedef enum logic [1:0] {
    PRB_IDLE,
    PRB_ARMED,
    PRB_STOPPING
  } pcr_probe_state_type;

endpackage

// *** hw/pcr_probe_sync.sv ***
`timescale 1ns/10ps

// Two-stage synchroniser per probe pin with falling-edge detect
module pcr_probe_sync (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] pin_in,
  output logic      [1:0] level,
  output logic      [1:0] fall
);

  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] prev_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall  = prev_q & ~sync_q;

endmodule

// *** test/pcr_host_model.sv ***
`timescale 1ns/10ps

// Host processor on the shared memory side; one strobe per taking edge
module pcr_host_model (
  input  wire logic        ref_clk,
  output logic      [10:0] hp_addr,
  output logic             hp_wr,
  output logic             hp_rd,
  output logic      [7:0]  hp_wdata,
  input  wire logic [7:0]  hp_rdata
);
  initial begin
    hp_addr  = 11'h7FF;
    hp_wr    = 1'b0;
    hp_rd    = 1'b0;
    hp_wdata = 8'hFF;
  end

  // Read: address held over the taking edge, data taken at the falling edge right after it
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    hp_addr = a;
    hp_rd   = 1'b1;
    @(negedge ref_clk);
    hp_rd   = 1'b0;
    hp_addr = ~a;
    d       = hp_rdata;
  endtask

  // Write: released lines show the inverse of the last value
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    hp_addr  = a;
    hp_wdata = d;
    hp_wr    = 1'b1;
    @(negedge ref_clk);
    hp_wr    = 1'b0;
    hp_addr  = ~a;
    hp_wdata = ~d;
  endtask

  // Host side of the capture handshake writes only its own byte
  task automatic ack_capture();
    wr(pcr_pkg::OFS_HS_HOST, pcr_pkg::HS_READY);
  endtask
endmodule

// *** test/tb.sv ***
`timescale 1ns/10ps

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end

module tb;
  typedef struct {logic [7:0] n; logic [7:0] m; logic [1:0] fall; logic hit;} pcr_row_type;

  logic         ref_clk;
  logic         arst_n;
  logic         cmd_valid;
  logic [7:0]   cmd_code;
  logic [7:0]   cmd_arg_a;
  logic [7:0]   cmd_arg_b;
  logic [1:0]   pr;
  logic         axes_stopped;
  logic [127:0] actual_pos;
  logic [127:0] pos;
  logic         fb_fault_valid;
  logic [3:0]   fb_fault_axes;
  logic [10:0]  hp_addr;
  logic         hp_wr;
  logic         hp_rd;
  logic [7:0]   hp_wdata;
  logic [7:0]   hp_rdata;
  logic         stop_all_axes;
  logic         soft_reset_pulse;
  logic         host_irq;
  int           n_fail;
  int           tests_run;
  pcr_row_type  rows [5] = '{'{8'h01, 8'h01, 2'b01, 1'b1}, '{8'h02, 8'h02, 2'b10, 1'b1},
                             '{8'h03, 8'h01, 2'b10, 1'b0}, '{8'h02, 8'h03, 2'b01, 1'b0},
                             '{8'h01, 8'h02, 2'b01, 1'b0}};
  logic [10:0]  regs [9] = '{11'h000, 11'h006, 11'h009, 11'h00A, 11'h0C8, 11'h0D0, 11'h3FE, 11'h7EF, 11'h7FE};

  pcr_cmd DUT (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_arg_a(cmd_arg_a), .cmd_arg_b(cmd_arg_b), .probe_input_zero(pr[0]), .probe_input_one(pr[1]),
    .axes_stopped(axes_stopped), .actual_pos(actual_pos), .fb_fault_valid(fb_fault_valid),
    .fb_fault_axes(fb_fault_axes), .hp_addr(hp_addr), .hp_wr(hp_wr), .hp_rd(hp_rd), .hp_wdata(hp_wdata),
    .hp_rdata(hp_rdata), .stop_all_axes(stop_all_axes), .soft_reset_pulse(soft_reset_pulse),
    .host_irq(host_irq));

  pcr_host_model host (.ref_clk(ref_clk), .hp_addr(hp_addr), .hp_wr(hp_wr), .hp_rd(hp_rd),
    .hp_wdata(hp_wdata), .hp_rdata(hp_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_rd(input logic [10:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    `CHK("shared memory byte", e, d)
  endtask

  task automatic send(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
    @(negedge ref_clk);
    cmd_code  = c;
    cmd_arg_a = a;
    cmd_arg_b = b;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask

  // Reset command; a good signature gives one pulse and reset flags
  task automatic soft_reset(input logic [7:0] a, input logic [7:0] b);
    int cnt;
    logic ok;
    cnt = 0;
    ok = (a == pcr_pkg::RESET_SIG) && (b == pcr_pkg::RESET_SIG);
    send(pcr_pkg::CMD_SOFT_RESET, a, b);
    for (int k = 0; k < 5; k++) begin
      if (soft_reset_pulse === 1'b1) cnt++;
      @(negedge ref_clk);
    end
    `CHK("reset pulse count", ok ? 1 : 0, cnt)
    if (ok) begin
      chk_rd(pcr_pkg::OFS_IRQ_LOW, pcr_pkg::FLAG_RESET_MASK);
      chk_rd(pcr_pkg::OFS_IRQ_HIGH_B, pcr_pkg::FLAG_RESET_MASK);
      chk_rd(pcr_pkg::OFS_IRQ_HIGH_A, 8'h00);
    end
  endtask

  task automatic fall_wait(input logic [1:0] f);
    int k;
    k = 0;
    pr = pr & ~f;
    while (stop_all_axes !== 1'b1 && k < 10) begin
      @(negedge ref_clk);
      k++;
    end
  endtask

  task automatic probe_row(input pcr_row_type r);
    axes_stopped = 1'b0;
    pos = {r.n, r.m, 112'h0E0D_0C0B_0A09_0807_0605_0403_0201};
    actual_pos = pos;
    send(pcr_pkg::CMD_PROBE_ARM, r.n, r.m);
    fall_wait(r.fall);
    `CHK("stop_all_axes", r.hit, stop_all_axes)
    actual_pos = ~pos;
    repeat (3) @(negedge ref_clk);
    `CHK("host_irq before stop", 1'b0, host_irq)
    axes_stopped = 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK("stop_all_axes released", 1'b0, stop_all_axes)
    `CHK("host_irq", r.hit, host_irq)
    if (r.hit) begin
      chk_rd(pcr_pkg::OFS_PROBE_EVENT, r.n);
      chk_rd(pcr_pkg::OFS_PROBE_ECHO, r.m);
      for (int i = 0; i < 16; i++) chk_rd(pcr_pkg::OFS_POS_FIRST + 11'(i), pos[8*i +: 8]);
      chk_rd(pcr_pkg::OFS_HS_CARD, pcr_pkg::HS_READY);
      host.ack_capture();
      chk_rd(pcr_pkg::OFS_HS_CARD, 8'h00);
      chk_rd(pcr_pkg::OFS_IRQ_LOW, 8'h02);
      chk_rd(pcr_pkg::OFS_IRQ_HIGH_A, 8'h02);
      pr = 2'b11;
      axes_stopped = 1'b0;
      repeat (3) @(negedge ref_clk);
      fall_wait(2'b11);
      `CHK("stop after disarm", 1'b0, stop_all_axes)
      `CHK("host_irq after disarm", 1'b0, host_irq)
    end
    pr = 2'b11;
    soft_reset(pcr_pkg::RESET_SIG, pcr_pkg::RESET_SIG);
  endtask

  initial begin
    n_fail = 0;
    tests_run = 0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_arg_a = 8'h00;
    cmd_arg_b = 8'h00;
    pr = 2'b11;
    axes_stopped = 1'b0;
    actual_pos = '0;
    fb_fault_valid = 1'b0;
    fb_fault_axes = 4'h0;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    `CHK("outputs after reset", 3'b000, {stop_all_axes, soft_reset_pulse, host_irq})
    foreach (regs[i]) chk_rd(regs[i], 8'h00);
    foreach (rows[i]) probe_row(rows[i]);
    // Feedback fault, then refused and accepted resets
    @(negedge ref_clk);
    fb_fault_axes = 4'h9;
    fb_fault_valid = 1'b1;
    @(negedge ref_clk);
    fb_fault_valid = 1'b0;
    @(negedge ref_clk);
    chk_rd(pcr_pkg::OFS_FB_STATUS, pcr_pkg::FB_OCCURRED);
    chk_rd(pcr_pkg::OFS_FB_SOURCE, 8'h09);
    soft_reset(8'hAA, 8'h55);
    soft_reset(8'h55, 8'hAA);
    chk_rd(pcr_pkg::OFS_IRQ_LOW, 8'h40);
    chk_rd(pcr_pkg::OFS_IRQ_HIGH_A, 8'h40);
    soft_reset(pcr_pkg::RESET_SIG, pcr_pkg::RESET_SIG);
    chk_rd(pcr_pkg::OFS_FB_SOURCE, 8'h00);
    host.wr(pcr_pkg::OFS_FB_STATUS, 8'hFF);
    chk_rd(pcr_pkg::OFS_FB_STATUS, 8'h00);
    chk_rd(11'h100, 8'h00);
    // Second arm replaces the first
    axes_stopped = 1'b0;
    send(pcr_pkg::CMD_PROBE_ARM, 8'h01, pcr_pkg::SEL_PROBE_ZERO);
    send(pcr_pkg::CMD_PROBE_ARM, 8'h02, pcr_pkg::SEL_PROBE_ONE);
    fall_wait(2'b01);
    `CHK("old probe disarmed", 1'b0, stop_all_axes)
    fall_wait(2'b10);
    `CHK("new probe armed", 1'b1, stop_all_axes)
    axes_stopped = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_rd(pcr_pkg::OFS_PROBE_ECHO, pcr_pkg::SEL_PROBE_ONE);
    chk_rd(pcr_pkg::OFS_PROBE_EVENT, 8'h02);
    report_and_stop();
  end

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
endmodule
